// ### logic/otp_fuse_defs.vh
/*
  constants for the one-time-programmable fuse register block:
  instruction codes, register widths, permission bit positions, burn timing.
  assumes inclusion by a module that uses it; definitions only.
*/
`ifndef OTP_FUSE_DEFS_VH
`define OTP_FUSE_DEFS_VH

`define IR_WIDTH 6
`define IR_AUTH_KEY_HASH 6'h18
`define IR_DECRYPT_KEY 6'h31
`define IR_UNIT_IDENTIFIER 6'h32
`define IR_USER_CODE_SHORT 6'h33
`define IR_USER_CODE_LONG 6'h19
`define IR_ACCESS_CONTROL 6'h34
`define IR_SECURITY_OPTION 6'h3B
`define IR_BYPASS 6'h3F

`define W_AUTH_KEY_HASH 384
`define W_DECRYPT_KEY 256
`define W_UNIT_IDENTIFIER 96
`define W_USER_CODE_SHORT 32
`define W_USER_CODE_LONG 128
`define W_USER_LONG_DR 176
`define W_ACCESS_CONTROL 24
`define W_SECURITY_OPTION 32
`define W_SHIFT 384

`define PB_RD_DIS_KEY 0
`define PB_RD_DIS_USER 1
`define PB_RD_DIS_SEC 2
`define PB_WR_DIS_CTRL 5
`define PB_RD_DIS_HASH 6
`define PB_WR_DIS_KEY 7
`define PB_WR_DIS_USER 8
`define PB_WR_DIS_SEC 9
`define PB_WR_DIS_HASH 15
`define PB_WR_DIS_USER_LONG 16
`define SEC_FORCE_OTP_KEY 1

`define BURN_TIME_NS 1000
`define CLK_PERIOD_NS 4

`endif

// ### logic/otp_fuse_register_access.v
/*
  fuse storage behind a test access port: seven fuse registers selected by
  6-bit instructions, shifted bit 0 first, programmed once by burning cells.
  assumes TCK is sampled as a synchronous input to CLK and edges are slow
  compared to CLK; the fuse array itself is modelled as flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otp_fuse_defs.vh"

// Contract
// - a blown cell reads 1, an untouched cell reads 0.
// - programming burns selected cells with a timed current pulse; burnt stays high.
// - a unique factory 96-bit identifier, readable over JTAG and from fabric.
// - 32-bit user code programmable over JTAG, readable over JTAG or fabric.
// - fabric sees only the short user code and the identifier; the code also exports the security-word key-select bit and burn status.
// - each register selected by instruction; programmed bits never clear.
// - authentication hash register, 384 bits, bit 0 shifted first.
// - 256-bit decrypt key, bit 0 first, selectable over battery-backed key.
// - identifier register shifts 96 factory bits, matching the fabric value.
// - short user code program and read gated by permission bits.
// - 24-bit control word sets permissions, programmable and readable over JTAG.
// - 32-bit security word, program and read gated by permission bits.
// - each register has its own 6-bit instruction code.
module otp_fuse_register_access #(
  // arbitrary value; every unit gets its own at build time
  parameter [95:0] FACTORY_ID = 96'h0123456789ABCDEF01234567,
  parameter BURN_CYCLES = (`BURN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire CLK,
  input wire SYS_RST,
  input wire TCK,
  input wire TMS,
  input wire TDI,
  output reg TDO,
  output reg TDO_OE,
  input wire PROGRAM_EN,
  output wire PROGRAM_BUSY,
  output wire [`W_UNIT_IDENTIFIER-1:0] UNIQUE_UNIT_ID,
  output wire [`W_USER_CODE_SHORT-1:0] FABRIC_USER_CODE,
  output wire FORCE_OTP_KEY
);
  reg tck_q;
  reg [3:0] tap_q;
  reg [3:0] tap_d;
  reg [`IR_WIDTH-1:0] ir_sh_q;
  reg [`IR_WIDTH-1:0] ir_q;
  reg [`W_SHIFT-1:0] dr_q;
  reg [`W_AUTH_KEY_HASH-1:0] hash_q;
  reg [`W_DECRYPT_KEY-1:0] key_q;
  reg [`W_USER_CODE_SHORT-1:0] user_q;
  reg [`W_USER_CODE_LONG-1:0] user_long_q;
  reg [`W_ACCESS_CONTROL-1:0] perm_q;
  reg [`W_SECURITY_OPTION-1:0] sec_q;
  reg [15:0] burn_cnt_q;
  reg [2:0] burn_sel_q;
  reg [`W_SHIFT-1:0] burn_data_q;
  reg [8:0] dr_len;
  reg [`W_SHIFT-1:0] cap;
  reg wr_ok;
  wire rise = TCK & ~tck_q;
  wire fall = ~TCK & tck_q;

  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_HASH = 3'h1;
  localparam [2:0] SEL_KEY = 3'h2;
  localparam [2:0] SEL_USER = 3'h3;
  localparam [2:0] SEL_ULONG = 3'h4;
  localparam [2:0] SEL_CTRL = 3'h5;
  localparam [2:0] SEL_SEC = 3'h6;
  localparam [3:0] TAP_RESET = 4'h0;
  localparam [3:0] TAP_IDLE = 4'h1;
  localparam [3:0] TAP_SEL_DR = 4'h2;
  localparam [3:0] TAP_CAP_DR = 4'h3;
  localparam [3:0] TAP_SH_DR = 4'h4;
  localparam [3:0] TAP_EX1_DR = 4'h5;
  localparam [3:0] TAP_PA_DR = 4'h6;
  localparam [3:0] TAP_EX2_DR = 4'h7;
  localparam [3:0] TAP_UPD_DR = 4'h8;
  localparam [3:0] TAP_SEL_IR = 4'h9;
  localparam [3:0] TAP_CAP_IR = 4'hA;
  localparam [3:0] TAP_SH_IR = 4'hB;
  localparam [3:0] TAP_EX1_IR = 4'hC;
  localparam [3:0] TAP_PA_IR = 4'hD;
  localparam [3:0] TAP_EX2_IR = 4'hE;
  localparam [3:0] TAP_UPD_IR = 4'hF;
  reg [2:0] sel;

  // fabric view: identifier, short user code, key-select bit and burn status leave the block
  assign UNIQUE_UNIT_ID = FACTORY_ID;
  assign FABRIC_USER_CODE = user_q;
  assign FORCE_OTP_KEY = sec_q[`SEC_FORCE_OTP_KEY];
  assign PROGRAM_BUSY = (burn_cnt_q != 16'h0000);

  always @*
  begin
    case (tap_q)
      TAP_RESET: tap_d = TMS ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_d = TMS ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_d = TMS ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_d = TMS ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_d = TMS ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_d = TMS ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tap_d = TMS ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_d = TMS ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_d = TMS ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_d = TMS ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_d = TMS ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_d = TMS ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_d = TMS ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tap_d = TMS ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_d = TMS ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_d = TMS ? TAP_SEL_DR : TAP_IDLE;
      default: tap_d = TAP_RESET;
    endcase
  end

  // instruction decode, capture value, length, write permission
  always @*
  begin
    sel = SEL_NONE;
    cap = {`W_SHIFT{1'b0}};
    dr_len = 9'h001;
    wr_ok = 1'b0;
    case (ir_q)
      `IR_AUTH_KEY_HASH:
      begin
        sel = SEL_HASH;
        dr_len = 9'h180;
        if (!perm_q[`PB_RD_DIS_HASH])
          cap = hash_q;
        wr_ok = ~perm_q[`PB_WR_DIS_HASH];
      end
      `IR_DECRYPT_KEY:
      begin
        sel = SEL_KEY;
        dr_len = 9'h100;
        // the key itself is never shifted back out
        wr_ok = ~perm_q[`PB_WR_DIS_KEY];
      end
      `IR_UNIT_IDENTIFIER:
      begin
        dr_len = 9'h060;
        cap[`W_UNIT_IDENTIFIER-1:0] = FACTORY_ID;
      end
      `IR_USER_CODE_SHORT:
      begin
        sel = SEL_USER;
        dr_len = 9'h020;
        if (!perm_q[`PB_RD_DIS_USER])
          cap[`W_USER_CODE_SHORT-1:0] = user_q;
        wr_ok = ~perm_q[`PB_WR_DIS_USER];
      end
      `IR_USER_CODE_LONG:
      begin
        sel = SEL_ULONG;
        dr_len = 9'h0B0;
        cap[`W_USER_CODE_LONG-1:0] = user_long_q;
        wr_ok = ~perm_q[`PB_WR_DIS_USER_LONG];
      end
      `IR_ACCESS_CONTROL:
      begin
        sel = SEL_CTRL;
        dr_len = 9'h018;
        cap[`W_ACCESS_CONTROL-1:0] = perm_q;
        wr_ok = ~perm_q[`PB_WR_DIS_CTRL];
      end
      `IR_SECURITY_OPTION:
      begin
        sel = SEL_SEC;
        dr_len = 9'h020;
        if (!perm_q[`PB_RD_DIS_SEC])
          cap[`W_SECURITY_OPTION-1:0] = sec_q;
        wr_ok = ~perm_q[`PB_WR_DIS_SEC];
      end
      default:
      begin
        dr_len = 9'h001;
      end
    endcase
  end

  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      tck_q <= 1'b0;
      tap_q <= TAP_RESET;
      ir_sh_q <= {`IR_WIDTH{1'b0}};
      ir_q <= `IR_BYPASS;
      dr_q <= {`W_SHIFT{1'b0}};
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end
    else
    begin
      tck_q <= TCK;
      if (rise)
      begin
        tap_q <= tap_d;
        case (tap_q)
          TAP_RESET: ir_q <= `IR_BYPASS;
          TAP_CAP_IR: ir_sh_q <= 6'h01;
          TAP_SH_IR: ir_sh_q <= {TDI, ir_sh_q[`IR_WIDTH-1:1]};
          TAP_UPD_IR: ir_q <= ir_sh_q;
          TAP_CAP_DR: dr_q <= cap;
          // bit 0 leaves first; new bit enters at the register's own top
          TAP_SH_DR:
          begin
            dr_q <= dr_q >> 1;
            dr_q[dr_len-9'h001] <= TDI;
          end
          default: dr_q <= dr_q;
        endcase
      end
      if (fall)
      begin
        TDO <= (tap_q == TAP_SH_IR) ? ir_sh_q[0] : dr_q[0];
        TDO_OE <= (tap_q == TAP_SH_IR) || (tap_q == TAP_SH_DR);
      end
    end
  end

  // fuse array: only ever ORs ones in, so a blown cell stays blown
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      // untouched cells read zero
      hash_q <= {`W_AUTH_KEY_HASH{1'b0}};
      key_q <= {`W_DECRYPT_KEY{1'b0}};
      user_q <= {`W_USER_CODE_SHORT{1'b0}};
      user_long_q <= {`W_USER_CODE_LONG{1'b0}};
      perm_q <= {`W_ACCESS_CONTROL{1'b0}};
      sec_q <= {`W_SECURITY_OPTION{1'b0}};
      burn_cnt_q <= 16'h0000;
      burn_sel_q <= SEL_NONE;
      burn_data_q <= {`W_SHIFT{1'b0}};
    end
    else if (burn_cnt_q != 16'h0000)
    begin
      burn_cnt_q <= burn_cnt_q - 16'h0001;
      if (burn_cnt_q == 16'h0001)
      begin
        case (burn_sel_q)
          SEL_HASH: hash_q <= hash_q | burn_data_q;
          SEL_KEY: key_q <= key_q | burn_data_q[`W_DECRYPT_KEY-1:0];
          SEL_USER: user_q <= user_q | burn_data_q[`W_USER_CODE_SHORT-1:0];
          SEL_ULONG: user_long_q <= user_long_q | burn_data_q[`W_USER_CODE_LONG-1:0];
          SEL_CTRL: perm_q <= perm_q | burn_data_q[`W_ACCESS_CONTROL-1:0];
          SEL_SEC: sec_q <= sec_q | burn_data_q[`W_SECURITY_OPTION-1:0];
          default: burn_sel_q <= SEL_NONE;
        endcase
      end
    end
    else if (rise && tap_q == TAP_UPD_DR && PROGRAM_EN && wr_ok && sel != SEL_NONE)
    begin
      // a later write can only add ones: each cell is blown once, never cleared
      burn_cnt_q <= BURN_CYCLES[15:0];
      burn_sel_q <= sel;
      burn_data_q <= dr_q;
    end
  end
endmodule
`default_nettype wire

// ### test/otp_fuse_properties.sv
/*
  port checker for the fuse register block, bound to its top module.
  assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module otp_fuse_properties #(
  parameter [95:0] FACTORY_ID = 96'h0,
  parameter BURN_CYCLES = 4
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic TCK,
  input wire logic TDO,
  input wire logic TDO_OE,
  input wire logic PROGRAM_EN,
  input wire logic PROGRAM_BUSY,
  input wire logic [95:0] UNIQUE_UNIT_ID,
  input wire logic [31:0] FABRIC_USER_CODE,
  input wire logic FORCE_OTP_KEY
);
  logic [15:0] cnt_q;
  always @(posedge CLK)
    cnt_q <= (SYS_RST || !PROGRAM_BUSY) ? 16'h0000 : cnt_q + 16'h0001;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  rst_quiet_a: assert property ($past(SYS_RST) |-> !TDO_OE && !PROGRAM_BUSY
    && FABRIC_USER_CODE == 32'h0 && !FORCE_OTP_KEY) else $error("not blank after reset");
  user_keep_a: assert property (!$past(SYS_RST) |->
    (FABRIC_USER_CODE & $past(FABRIC_USER_CODE)) == $past(FABRIC_USER_CODE))
    else $error("user code bit cleared");
  user_burn_a: assert property (!$past(SYS_RST) && $changed(FABRIC_USER_CODE)
    |-> $past(PROGRAM_BUSY)) else $error("user code changed without burn");
  key_keep_a: assert property (!$past(SYS_RST) |-> !$fell(FORCE_OTP_KEY))
    else $error("key select cleared");
  id_fixed_a: assert property (UNIQUE_UNIT_ID == FACTORY_ID)
    else $error("identifier wrong");
  burn_len_a: assert property ($fell(PROGRAM_BUSY) |-> cnt_q == BURN_CYCLES)
    else $error("burn length wrong");
  tdo_edge_a: assert property (!$past(SYS_RST) && $changed(TDO) |-> !TCK && !$past(TCK))
    else $error("serial out moved off test clock fall");
  oe_edge_a: assert property (!$past(SYS_RST) && $changed(TDO_OE)
    |-> !TCK && !$past(TCK)) else $error("serial enable moved off test clock fall");
  burn_cause_a: assert property ($rose(PROGRAM_BUSY) |-> TCK && $past(PROGRAM_EN))
    else $error("burn without enable");
  cover property ($rose(PROGRAM_BUSY));
  cover property ($rose(FORCE_OTP_KEY));
  cover property ($rose(TDO_OE));
endmodule
bind otp_fuse_register_access otp_fuse_properties #(.FACTORY_ID(FACTORY_ID),
  .BURN_CYCLES(BURN_CYCLES)) props (.CLK(CLK), .SYS_RST(SYS_RST), .TCK(TCK),
  .TDO(TDO), .TDO_OE(TDO_OE), .PROGRAM_EN(PROGRAM_EN), .PROGRAM_BUSY(PROGRAM_BUSY),
  .UNIQUE_UNIT_ID(UNIQUE_UNIT_ID), .FABRIC_USER_CODE(FABRIC_USER_CODE),
  .FORCE_OTP_KEY(FORCE_OTP_KEY));
`default_nettype wire

// ### test/jtag_host_model.sv
/*
  external test-port programmer: walks the TAP and shifts IR or DR scans.
  assumes its tasks are called just after a falling edge of CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
  input wire logic CLK,
  input wire logic TDO,
  output logic TCK = 1'b0,
  output logic TMS = 1'b1,
  output logic TDI = 1'b0
);
  logic so;
  // each test clock phase is 4 system clocks, above the 3 the block needs
  task automatic tick(input logic m, input logic d);
    TMS = m;
    TDI = d;
    repeat (4) @(negedge CLK);
    so = TDO;
    TCK = 1'b1;
    repeat (4) @(negedge CLK);
    TCK = 1'b0;
  endtask
  // data in outside shifting is not meaningful, so it toggles
  task automatic scan(input logic is_ir, input int n, input logic [383:0] din,
    output logic [383:0] dout);
    dout = 384'h0;
    tick(1'b1, ~TDI);
    if (is_ir)
      tick(1'b1, ~TDI);
    tick(1'b0, ~TDI);
    tick(1'b0, ~TDI);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i]);
      dout[i] = so;
    end
    tick(1'b1, ~TDI);
    tick(1'b0, ~TDI);
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
/*
  testbench for the fuse register block: scans through the host model.
  assumes the short burn parameter so runs stay brief.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otp_fuse_defs.vh"
module tb_top;
  localparam [95:0] FID = 96'hA5C30F1E2D3C4B5A69788796; // arbitrary value
  localparam [383:0] HASH = {8'h81, 368'h0, 8'h3C};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic program_en = 1'b0;
  logic [383:0] q;
  wire tck, tms, tdi, tdo, tdo_oe, busy, use_key;
  wire [95:0] uid;
  wire [31:0] ucode;
  integer error_cnt = 0;
  integer total_checks = 0;
  always #2 clk = ~clk;
  otp_fuse_register_access #(.FACTORY_ID(FID), .BURN_CYCLES(4)) dut (.CLK(clk),
    .SYS_RST(sys_rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
    .PROGRAM_EN(program_en), .PROGRAM_BUSY(busy), .UNIQUE_UNIT_ID(uid),
    .FABRIC_USER_CODE(ucode), .FORCE_OTP_KEY(use_key));
  jtag_host_model host (.CLK(clk), .TDO(tdo), .TCK(tck), .TMS(tms), .TDI(tdi));
  task automatic check(input logic [383:0] got, input logic [383:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h", $time, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic op(input logic [5:0] c, input int n, input logic [383:0] d);
    host.scan(1'b1, 6, {378'h0, c}, q);
    check(q[5:0], 6'h01);
    host.scan(1'b0, n, d, q);
    // back in idle the serial output must be released
    check(tdo_oe, 384'h0);
    for (int i = 0; i < 300 && busy !== 1'b0; i++)
      @(negedge clk);
    if (busy !== 1'b0)
    begin
      error_cnt++;
      $display("unexpected at %0t: burn never ends", $time);
      give_verdict;
    end
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    check(ucode, 384'h0);
    check(use_key, 384'h0);
    host.tick(1'b0, 1'b0);
    op(`IR_UNIT_IDENTIFIER, 96, 384'h0);
    check(q[95:0], FID);
    check(uid, FID);
    // the bench runs no configuration traffic, so burning may start here
    program_en = 1'b1;
    op(`IR_USER_CODE_SHORT, 32, 384'hF0);
    op(`IR_USER_CODE_SHORT, 32, 384'hF0F);
    check(ucode, 384'hFFF);
    op(`IR_USER_CODE_SHORT, 32, 384'h0);
    check(q[31:0], 384'hFFF);
    $display("test user code done");
    op(`IR_AUTH_KEY_HASH, 384, HASH);
    op(`IR_AUTH_KEY_HASH, 384, 384'h0);
    check(q, HASH);
    op(`IR_USER_CODE_LONG, 176, {128'h0, 256'h80000000000000000000000000000001});
    op(`IR_USER_CODE_LONG, 176, 384'h0);
    check(q[127:0], 384'h80000000000000000000000000000001);
    op(`IR_DECRYPT_KEY, 256, 384'hFF);
    op(`IR_DECRYPT_KEY, 256, 384'h0);
    check(q[255:0], 384'h0);
    op(`IR_SECURITY_OPTION, 32, 384'h2);
    check(use_key, 384'h1);
    op(`IR_SECURITY_OPTION, 32, 384'h0);
    check(q[31:0], 384'h2);
    $display("test key registers done");
    op(`IR_ACCESS_CONTROL, 24, 384'h106);
    op(`IR_ACCESS_CONTROL, 24, 384'h0);
    check(q[23:0], 384'h106);
    op(`IR_USER_CODE_SHORT, 32, 384'hF0000000);
    check(ucode, 384'hFFF);
    op(`IR_USER_CODE_SHORT, 32, 384'h0);
    check(q[31:0], 384'h0);
    op(`IR_SECURITY_OPTION, 32, 384'h0);
    check(q[31:0], 384'h0);
    check(ucode, 384'hFFF);
    // lock the control word and hide the hash, then try to change the lock
    op(`IR_ACCESS_CONTROL, 24, 384'h8060);
    op(`IR_ACCESS_CONTROL, 24, 384'h10000);
    op(`IR_ACCESS_CONTROL, 24, 384'h0);
    check(q[23:0], 384'h8166);
    op(`IR_AUTH_KEY_HASH, 384, 384'h0);
    check(q, 384'h0);
    $display("test permissions done");
    give_verdict;
  end
endmodule
`default_nettype wire
